// *** logic/sram_pin_defs.vh ***
// constants for the pipelined sram pin-control block
// assumes one system clock mclk at 100 MHz, test clock on its own pin
`ifndef SRAM_PIN_DEFS_VH
`define SRAM_PIN_DEFS_VH
`define ADDR_WIDTH 10
`define LANE_COUNT 4
`define LANE_BITS 8
`define BURST_LEN 4
`define MODE_INTERLEAVED 1'b1
`define MODE_LINEAR 1'b0
`define OP_IDLE 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2
`define SCAN_LEN 8
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1 4'h5
`define TAP_PAUSE 4'h6
`define TAP_EXIT2 4'h7
`define TAP_UPDATE 4'h8
`define TAP_SEL_IR 4'h9
`endif

// *** logic/lane_memory.v ***
// storage array with per-lane write enables and registered read data
// assumes the caller qualifies the write and read strobes
`timescale 1ns/1ps
`include "sram_pin_defs.vh"
module lane_memory #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter LANES = `LANE_COUNT,
  parameter LANE_BITS = `LANE_BITS
) (
  // clock
  input wire mclk,
  // write side
  input wire wr_en,
  input wire [LANES-1:0] lane_en,
  input wire [ADDR_WIDTH-1:0] wr_addr,
  input wire [LANES*LANE_BITS-1:0] wr_data,
  // read side
  input wire rd_en,
  input wire [ADDR_WIDTH-1:0] rd_addr,
  output reg [LANES*LANE_BITS-1:0] rd_data
);
  reg [LANES*LANE_BITS-1:0] mem [0:(1<<ADDR_WIDTH)-1];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      always @(posedge mclk) begin
        if (wr_en && lane_en[g]) begin
          mem[wr_addr][g*LANE_BITS +: LANE_BITS] <= wr_data[g*LANE_BITS +: LANE_BITS];
        end
      end
    end
  endgenerate
  always @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // lane_memory

// *** logic/sram_pin_control.v ***
// pin-level control of a pipelined burst sram: data/parity direction, clock
// qualify, byte writes, burst order strap, sleep, and boundary-scan pins.
// assumes the controller drives inputs synchronous to mclk; tck is a pin clock.
// What this block does
// - drive data pins when enable low
// - tri-state data pins when enable high
// - force tri-state on write, emerge, deselect
// - act only on qualified clock edges
// - qualifier high holds state, no deselect
// - capture input data on rising edge
// - read data pipelined one edge later
// - parity lanes follow own byte select
// - strap high interleaved, low linear
// - strap tracked each edge, expected constant; open-strap pull resolved outside
// - scan output changes on falling tck
// - scan input sampled on rising tck
// - mode select steps tap on rising
// - sleep input enters retaining sleep state
// - sleep pin pull-down left to the pad, outside this block
// - byte selects active low, need write
`timescale 1ns/1ps
`include "sram_pin_defs.vh"
module sram_pin_control #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter LANES = `LANE_COUNT,
  parameter LANE_BITS = `LANE_BITS
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // controls
  input wire clock_qualify_n,
  input wire chip_select,
  input wire write_select_n,
  input wire advance_load,
  input wire output_drive_n,
  input wire [LANES-1:0] byte_write_select_n,
  input wire [ADDR_WIDTH-1:0] address,
  // strap and sleep (pin-level pull values are resolved outside)
  input wire burst_mode,
  input wire sleep_request,
  output wire sleep_active,
  // data and parity lanes
  input wire [LANES*LANE_BITS-1:0] data_in,
  output reg [LANES*LANE_BITS-1:0] data_out,
  output wire [LANES*LANE_BITS-1:0] data_oe,
  input wire [LANES-1:0] parity_io_in,
  output reg [LANES-1:0] parity_io_out,
  output wire [LANES-1:0] parity_io_oe,
  // boundary scan
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output wire tdo_oe
);
  localparam W = LANES * (LANE_BITS + 1);
  // per-lane storage packs parity as the ninth bit
  wire [W-1:0] rd_word;
  wire [W-1:0] wr_word;
  reg [1:0] op_reg, op_next;
  reg [1:0] data_op_reg;
  reg sel_reg;
  reg emerge_reg;
  reg burst_mode_reg;
  reg [ADDR_WIDTH-1:0] base_reg;
  reg [1:0] count_reg;
  reg [LANES-1:0] lanes_reg;
  reg [ADDR_WIDTH-1:0] wr_addr_reg;
  reg [LANES-1:0] wr_lanes_reg;
  reg read_pending_reg;
  wire edge_ok;
  wire [1:0] seq;
  wire [ADDR_WIDTH-1:0] cur_addr;
  wire do_write;
  wire drive;
  wire [1:0] next_count;
  wire [1:0] adv_seq;
  wire [ADDR_WIDTH-1:0] rd_addr;
  wire rd_go;
  integer i;
  assign edge_ok = ~clock_qualify_n & ~sleep_request;
  assign sleep_active = sleep_request;
  assign seq = (burst_mode_reg == `MODE_INTERLEAVED) ? (base_reg[1:0] ^ count_reg)
                                                     : (base_reg[1:0] + count_reg);
  assign cur_addr = {base_reg[ADDR_WIDTH-1:2], seq};
  // read launched at the load or advance edge, so the output register
  // holds the word one qualified edge later
  assign next_count = count_reg + 2'h1;
  assign adv_seq = (burst_mode_reg == `MODE_INTERLEAVED) ? (base_reg[1:0] ^ next_count)
                                                         : (base_reg[1:0] + next_count);
  assign rd_addr = advance_load ? {base_reg[ADDR_WIDTH-1:2], adv_seq} : address;
  assign rd_go = edge_ok && (op_next == `OP_READ);
  always @* begin
    op_next = op_reg;
    if (advance_load) begin
      op_next = op_reg;
    end else if (!chip_select) begin
      op_next = `OP_IDLE;
    end else if (!write_select_n) begin
      op_next = `OP_WRITE;
    end else begin
      op_next = `OP_READ;
    end
  end
  // nothing changes while the qualifier is high
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      op_reg <= `OP_IDLE;
      data_op_reg <= `OP_IDLE;
      sel_reg <= 1'b0;
      emerge_reg <= 1'b0;
      base_reg <= {ADDR_WIDTH{1'b0}};
      count_reg <= 2'h0;
      lanes_reg <= {LANES{1'b0}};
      wr_addr_reg <= {ADDR_WIDTH{1'b0}};
      wr_lanes_reg <= {LANES{1'b0}};
      read_pending_reg <= 1'b0;
      burst_mode_reg <= `MODE_INTERLEAVED;
    end else if (edge_ok) begin
      // strap tracked; expected constant in use
      burst_mode_reg <= burst_mode;
      op_reg <= op_next;
      if (!advance_load) begin
        base_reg <= address;
        count_reg <= 2'h0;
        sel_reg <= chip_select;
        emerge_reg <= chip_select & ~sel_reg;
      end else begin
        count_reg <= count_reg + 2'h1;
        emerge_reg <= 1'b0;
      end
      // active-low byte selects taken with the write
      lanes_reg <= ~byte_write_select_n;
      // data phase trails the address phase by one edge
      data_op_reg <= op_reg;
      wr_addr_reg <= cur_addr;
      wr_lanes_reg <= lanes_reg;
      // read data one qualified edge after address
      read_pending_reg <= (op_reg == `OP_READ) && sel_reg;
    end
  end
  // data pins captured on the rising edge; write led by write select
  // a deselect after the load must not cancel the write already in flight
  assign do_write = edge_ok && (data_op_reg == `OP_WRITE);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : pack
      // parity stored beside its byte lane
      assign wr_word[g*(LANE_BITS+1) +: LANE_BITS+1] =
        {parity_io_in[g], data_in[g*LANE_BITS +: LANE_BITS]};
    end
  endgenerate
  lane_memory #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .LANES(LANES),
    .LANE_BITS(LANE_BITS + 1)
  ) u_mem (
    .mclk(mclk),
    .wr_en(do_write),
    .lane_en(wr_lanes_reg),
    .wr_addr(wr_addr_reg),
    .wr_data(wr_word),
    .rd_en(rd_go),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= {LANES*LANE_BITS{1'b0}};
      parity_io_out <= {LANES{1'b0}};
    end else if (edge_ok) begin
      for (i = 0; i < LANES; i = i + 1) begin
        data_out[i*LANE_BITS +: LANE_BITS] <= rd_word[i*(LANE_BITS+1) +: LANE_BITS];
        parity_io_out[i] <= rd_word[i*(LANE_BITS+1) + LANE_BITS];
      end
    end
  end
  // masked on write data, emerge and deselect
  // asynchronous output-drive enable gates last
  // deselect is pipelined: read data in flight still leaves, then pins float
  assign drive = read_pending_reg & ~output_drive_n & ~emerge_reg
                 & (data_op_reg != `OP_WRITE);
  assign data_oe = {LANES*LANE_BITS{drive}};
  assign parity_io_oe = {LANES{drive}};
  // boundary-scan tap and a bypass-style shift path
  reg [3:0] tap_reg, tap_next;
  reg [`SCAN_LEN-1:0] scan_reg;
  always @* begin
    case (tap_reg)
      `TAP_RESET: tap_next = tms ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: tap_next = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: tap_next = tms ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: tap_next = tms ? `TAP_EXIT1 : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: tap_next = tms ? `TAP_EXIT1 : `TAP_SHIFT_DR;
      `TAP_EXIT1: tap_next = tms ? `TAP_UPDATE : `TAP_PAUSE;
      `TAP_PAUSE: tap_next = tms ? `TAP_EXIT2 : `TAP_PAUSE;
      `TAP_EXIT2: tap_next = tms ? `TAP_UPDATE : `TAP_SHIFT_DR;
      `TAP_UPDATE: tap_next = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: tap_next = tms ? `TAP_RESET : `TAP_IDLE;
      default: tap_next = `TAP_RESET;
    endcase
  end
  // tms steps the tap; tdi sampled on rising tck
  always @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tap_reg <= `TAP_RESET;
      scan_reg <= {`SCAN_LEN{1'b0}};
    end else begin
      tap_reg <= tap_next;
      if (tap_reg == `TAP_SHIFT_DR) begin
        scan_reg <= {tdi, scan_reg[`SCAN_LEN-1:1]};
      end
    end
  end
  reg shift_out_reg;
  always @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tdo <= 1'b0;
      shift_out_reg <= 1'b0;
    end else begin
      tdo <= scan_reg[0];
      shift_out_reg <= (tap_reg == `TAP_SHIFT_DR);
    end
  end
  assign tdo_oe = shift_out_reg;
  // pull-down on sleep pin is a pad matter outside this logic
endmodule // sram_pin_control

// *** test/sram_pin_control_monitor.sv ***
// checker for the sram pin-control block
// sees only the top module ports; bound after the module
`timescale 1ns/1ps
module sram_pin_monitor #(parameter LANES = 4, parameter LANE_BITS = 8) (
  // clock and controls
  input wire mclk,
  input wire reset_n,
  input wire clock_qualify_n,
  input wire chip_select,
  input wire write_select_n,
  input wire advance_load,
  input wire output_drive_n,
  input wire sleep_request,
  input wire sleep_active,
  // data and parity lanes
  input wire [LANES*LANE_BITS-1:0] data_out,
  input wire [LANES*LANE_BITS-1:0] data_oe,
  input wire [LANES-1:0] parity_io_out,
  input wire [LANES-1:0] parity_io_oe
);
  localparam W = LANES*LANE_BITS;
  wire q = !clock_qualify_n && !sleep_request;
  wire ld = q && !advance_load;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence rd_load; ld && chip_select && write_select_n; endsequence
  sequence wr_load; ld && chip_select && !write_select_n; endsequence
  sequence desel; ld && !chip_select; endsequence
  chk_oe_off: assert property (output_drive_n |-> data_oe == 0)
    else $error("data driven with enable high");
  chk_lanes_same: assert property (data_oe == {W{parity_io_oe[0]}})
    else $error("lane enables differ");
  chk_qual_hold: assert property (clock_qualify_n |=> $stable(data_out))
    else $error("output moved on ignored edge");
  chk_sleep_hold: assert property (sleep_request |=> $stable(parity_io_out))
    else $error("parity moved in sleep");
  chk_sleep_copy: assert property (sleep_active == sleep_request)
    else $error("sleep flag wrong");
  chk_write_mask: assert property (wr_load ##1 q |=> !data_oe[0])
    else $error("driven in write data cycle");
  chk_desel_off: assert property (desel ##1 q |=> !data_oe[0])
    else $error("driven after deselect");
  chk_read_drive: assert property (rd_load [*4] ##1 !output_drive_n |-> data_oe[0])
    else $error("read data not driven");
endmodule // sram_pin_monitor
bind sram_pin_control sram_pin_monitor #(.LANES(LANES), .LANE_BITS(LANE_BITS)) u_mon (
  .mclk, .reset_n, .clock_qualify_n, .chip_select, .write_select_n, .advance_load,
  .output_drive_n, .sleep_request, .sleep_active, .data_out, .data_oe, .parity_io_out,
  .parity_io_oe);

// *** test/mem_ctrl_model.sv ***
// memory controller model: address, controls and write data
// assumes the bench resolves the shared data wire from data_oe
`timescale 1ns/1ps
module mem_ctrl_model #(parameter ADDR_WIDTH = 10, parameter LANES = 4) (
  // clock
  input wire mclk,
  // controls
  output reg clock_qualify_n,
  output reg chip_select,
  output reg write_select_n,
  output reg advance_load,
  output reg [LANES-1:0] byte_write_select_n,
  output reg [ADDR_WIDTH-1:0] address,
  // parity and data driven toward the device
  output reg [LANES*9-1:0] drive_bits
);
  initial begin
    {clock_qualify_n, chip_select, write_select_n, advance_load} = 4'ha;
    byte_write_select_n = {LANES{1'b1}};
    address = {ADDR_WIDTH{1'b0}};
    drive_bits = {LANES*9{1'b0}};
  end
  // released bus toggles so stale data never looks valid
  task cyc(input [1:0] kind, input [ADDR_WIDTH-1:0] a, input [LANES*9-1:0] d,
      input [LANES-1:0] bw, input drv);
    @(negedge mclk);
    clock_qualify_n = 1'b0;
    advance_load = 1'b0;
    chip_select = (kind != 2'h0);
    write_select_n = (kind != 2'h2);
    address = a;
    byte_write_select_n = bw;
    drive_bits = drv ? d : ~drive_bits;
  endtask
  // advance keeps the op and steps the burst counter
  task adv;
    @(negedge mclk);
    clock_qualify_n = 1'b0;
    advance_load = 1'b1;
    drive_bits = ~drive_bits;
  endtask
  task stall(input integer n);
    repeat (n) begin
      @(negedge mclk);
      clock_qualify_n = 1'b1;
      drive_bits = ~drive_bits;
    end
  endtask
endmodule // mem_ctrl_model

// *** test/sram_pin_control_tb.sv ***
// bench for sram pin control: writes, byte writes, stalls, sleep, bursts, scan
// assumes mem_ctrl_model and the bound checker
`timescale 1ns/1ps
`include "sram_pin_defs.vh"
module sram_pin_control_tb;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg output_drive_n = 1'b0;
  reg sleep_request = 1'b0;
  reg tck = 1'b0;
  reg tms = 1'b1;
  reg tdi = 1'b0;
  wire tdo, tdo_oe;
  wire clock_qualify_n, chip_select, write_select_n, advance_load, sleep_active;
  wire [3:0] byte_write_select_n, parity_io_out, parity_io_oe;
  wire [9:0] address;
  wire [35:0] drive_bits;
  wire [31:0] data_out, data_oe;
  wire [31:0] data_in = data_oe[0] ? data_out : drive_bits[31:0];
  wire [3:0] parity_io_in = parity_io_oe[0] ? parity_io_out : drive_bits[35:32];
  integer fail_count = 0;
  integer num_checks = 0;
  integer cycles = 0;
  always #5 mclk = ~mclk;
  // strap held high for the whole run; sleep held low except in t_sleep
  sram_pin_control u_dut (.mclk, .reset_n, .clock_qualify_n, .chip_select, .write_select_n,
    .advance_load, .output_drive_n, .byte_write_select_n, .address, .burst_mode(1'b1),
    .sleep_request, .sleep_active, .data_in, .data_out, .data_oe, .parity_io_in,
    .parity_io_out, .parity_io_oe, .tck, .tms, .tdi, .tdo, .tdo_oe);
  mem_ctrl_model u_ctrl (.mclk, .clock_qualify_n, .chip_select, .write_select_n,
    .advance_load, .byte_write_select_n, .address, .drive_bits);
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input [35:0] got, input [35:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // write data rides two edges behind the load; pins are masked meanwhile
  task wr(input [9:0] a, input [35:0] d, input [3:0] bw);
    u_ctrl.cyc(`OP_WRITE, a, d, bw, 1'b0);
    u_ctrl.cyc(`OP_IDLE, a, d, 4'hf, 1'b0);
    u_ctrl.cyc(`OP_IDLE, a, d, 4'hf, 1'b1);
    #1 chk({4'h0, data_oe}, 36'h0);
    u_ctrl.stall(1);
  endtask
  // single read: data one qualified edge after the load, gone after deselect
  task rd(input [9:0] a, input [35:0] exp, input integer st);
    u_ctrl.cyc(`OP_READ, a, 36'h0, 4'hf, 1'b0);
    u_ctrl.stall(st);
    u_ctrl.cyc(`OP_IDLE, a, 36'h0, 4'hf, 1'b0);
    u_ctrl.stall(1);
    #1 chk({parity_io_out, data_out}, exp);
    chk({4'h0, data_oe}, 36'h0_ffff_ffff);
    output_drive_n = 1'b1;
    #1 chk({4'h0, data_oe}, 36'h0);
    output_drive_n = 1'b0;
    u_ctrl.cyc(`OP_IDLE, a, 36'h0, 4'hf, 1'b0);
    u_ctrl.stall(1);
    #1 chk({4'h0, data_oe}, 36'h0);
  endtask
  task t_basic;
    wr(10'h005, 36'h9_a5c3_1e77, 4'h0);
    rd(10'h005, 36'h9_a5c3_1e77, 0);
  endtask
  task t_byte;
    wr(10'h005, 36'h6_0000_ff00, 4'hd);
    rd(10'h005, 36'hb_a5c3_ff77, 0);
  endtask
  task t_stall;
    rd(10'h005, 36'hb_a5c3_ff77, 3);
  endtask
  task t_sleep;
    @(negedge mclk);
    sleep_request = 1'b1;
    #1 chk({35'h0, sleep_active}, 36'h1);
    wr(10'h005, 36'h0_1234_5678, 4'h0);
    sleep_request = 1'b0;
    rd(10'h005, 36'hb_a5c3_ff77, 0);
  endtask
  task t_burst;
    wr(10'h008, 36'h4_4444_4444, 4'h0);
    wr(10'h009, 36'h1_1111_1111, 4'h0);
    wr(10'h00a, 36'h2_2222_2222, 4'h0);
    wr(10'h00b, 36'h3_3333_3333, 4'h0);
    // back-to-back loads: one word per edge, each one edge late
    u_ctrl.cyc(`OP_READ, 10'h008, 36'h0, 4'hf, 1'b0);
    u_ctrl.cyc(`OP_READ, 10'h009, 36'h0, 4'hf, 1'b0);
    u_ctrl.cyc(`OP_READ, 10'h00a, 36'h0, 4'hf, 1'b0);
    #1 chk({parity_io_out, data_out}, 36'h4_4444_4444);
    u_ctrl.cyc(`OP_READ, 10'h00b, 36'h0, 4'hf, 1'b0);
    #1 chk({parity_io_out, data_out}, 36'h1_1111_1111);
    u_ctrl.cyc(`OP_IDLE, 10'h000, 36'h0, 4'hf, 1'b0);
    #1 chk({parity_io_out, data_out}, 36'h2_2222_2222);
    u_ctrl.stall(1);
    #1 chk({parity_io_out, data_out}, 36'h3_3333_3333);
    chk({4'h0, data_oe}, 36'h0_ffff_ffff);
    // interleaved burst from offset 1 visits 1, 0, 3, 2
    u_ctrl.cyc(`OP_READ, 10'h009, 36'h0, 4'hf, 1'b0);
    u_ctrl.adv;
    u_ctrl.adv;
    #1 chk({parity_io_out, data_out}, 36'h1_1111_1111);
    u_ctrl.adv;
    #1 chk({parity_io_out, data_out}, 36'h4_4444_4444);
    u_ctrl.cyc(`OP_IDLE, 10'h000, 36'h0, 4'hf, 1'b0);
    #1 chk({parity_io_out, data_out}, 36'h3_3333_3333);
    u_ctrl.stall(1);
    #1 chk({parity_io_out, data_out}, 36'h2_2222_2222);
  endtask
  // one test-clock period: rises on one mclk fall, drops on the next
  task tstep(input m, input d);
    @(negedge mclk);
    tms = m;
    tdi = d;
    @(negedge mclk);
    tck = 1'b1;
    @(negedge mclk);
    tck = 1'b0;
  endtask
  task t_scan;
    reg [7:0] pat;
    integer i;
    pat = 8'h5a;
    tstep(1'b0, 1'b0);
    tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0);
    #1 chk({35'h0, tdo_oe}, 36'h0);
    tstep(1'b0, 1'b0);
    #1 chk({35'h0, tdo_oe}, 36'h1);
    for (i = 0; i < 15; i = i + 1) begin
      @(negedge mclk);
      tms = 1'b0;
      tdi = (i < 8) ? pat[i] : 1'b0;
      @(negedge mclk);
      tck = 1'b1;
      #1 if (i >= 8) chk({35'h0, tdo}, {35'h0, pat[i-8]});
      @(negedge mclk);
      tck = 1'b0;
      #1 if (i >= 7) chk({35'h0, tdo}, {35'h0, pat[i-7]});
    end
    tstep(1'b1, 1'b0);
    #1 chk({35'h0, tdo_oe}, 36'h0);
    tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0);
  endtask
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    t_basic;
    t_byte;
    t_stall;
    t_sleep;
    t_burst;
    t_scan;
    give_verdict;
  end
endmodule // sram_pin_control_tb
